// >>> logic/tsr_top.v
// Purpose : Digital side of a temperature sensor with a three-wire link
// Assumes : Converter logic runs on clk; link pins are asynchronous
// Notes   : Host samples data on serial_clk rise, device shifts on fall
`include "tsr_defs.vh"
`timescale 1ns/100ps
`default_nettype none

module tsr_top (
    input  wire        clk,                 // 25 MHz system clock
    input  wire        rst_n,               // Asynchronous reset, active low
    input  wire        cs_n,                // Chip select pin, active low
    input  wire        serial_clk,          // Serial clock pin from host
    input  wire        sio_in,              // Data pin, input side
    output wire        sio_out,             // Data pin, output side
    output wire        sio_oe,              // Data pin drive enable
    output wire        over_limit_alarm_n,  // Over-temperature output, active low
    output wire        conv_start,          // One-cycle pulse starting a conversion
    output wire [1:0]  conv_res,            // Resolution for the converter
    input  wire        conv_done,           // One-cycle pulse, conversion finished
    input  wire [15:0] conv_data            // Raw result, valid with conv_done
);

    // ************************************************************
    // Local codes
    // ************************************************************
    localparam [1:0] P_IDLE = 2'h0;         // No transaction
    localparam [1:0] P_TEMP = 2'h1;         // Temperature word out
    localparam [1:0] P_CMD  = 2'h2;         // Command byte in
    localparam [1:0] P_DATA = 2'h3;         // Register data in or out
    localparam       C_IDLE = 1'b0;         // Converter idle
    localparam       C_BUSY = 1'b1;         // Conversion running

    // ************************************************************
    // Declarations
    // ************************************************************
    reg  [2:0]  cs_sync_q;                  // Chip select synchroniser and delay
    reg  [2:0]  sc_sync_q;                  // Serial clock synchroniser and delay
    reg  [1:0]  si_sync_q;                  // Data input synchroniser
    reg  [1:0]  phase_q;                    // Link phase
    reg  [4:0]  cnt_q;                      // Rising edges in current field
    reg  [15:0] sh_q;                       // Shift register
    reg         rd_q;                       // Current data field is a read
    reg  [2:0]  ptr_q;                      // Register pointer of the command
    reg         sio_out_q;                  // Data pin level
    reg         sio_oe_q;                   // Data pin enable
    reg         shdn_q;                     // Shutdown control
    reg  [1:0]  res_q;                      // Resolution control
    reg  [15:0] high_q;                     // High limit
    reg  [15:0] low_q;                      // Low limit
    reg         os_go_q;                    // One-shot request pulse
    reg         aclr_q;                     // Alarm clear pulse
    reg         cst_q;                      // Converter state
    reg         start_q;                    // Conversion start pulse
    reg         pend_q;                     // One-shot pending
    reg         ready_q;                    // Result ready flag
    reg  [15:0] temp_q;                     // Last completed result
    reg         alarm_q;                    // Alarm state, active high
    reg         alarm_n_q;                  // Alarm pin level
    reg  [15:0] temp_fmt;                   // Result masked to resolution
    reg  [15:0] rd_word;                    // Word for a register read
    wire [15:0] temp_view;                  // Temperature as seen by reads
    wire        cs_hi;                      // Synchronised chip select high
    wire        cs_fall;                    // Chip select fell
    wire        sc_rise;                    // Serial clock rose
    wire        sc_fall;                    // Serial clock fell
    wire        si;                         // Synchronised data input
    wire [4:0]  cnt_n;                      // Count after this rising edge
    wire [7:0]  byte_in;                    // Byte completed at this rising edge
    wire        wr_now;                     // Write field takes a bit now
    wire [15:0] ctrl_word;                  // Control and status readback

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    // Two flops per pin, third stage only for edge detection
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_sync_q <= 3'h7;
            sc_sync_q <= 3'h0;
            si_sync_q <= 2'h0;
        end else begin
            cs_sync_q <= {cs_sync_q[1:0], cs_n};
            sc_sync_q <= {sc_sync_q[1:0], serial_clk};
            si_sync_q <= {si_sync_q[0], sio_in};
        end
    end

    assign cs_hi   = cs_sync_q[1];
    assign cs_fall = cs_sync_q[2] & ~cs_sync_q[1];
    assign sc_rise = sc_sync_q[1] & ~sc_sync_q[2];
    assign sc_fall = sc_sync_q[2] & ~sc_sync_q[1];
    assign si      = si_sync_q[1];
    assign cnt_n   = cnt_q + 5'd1;
    assign byte_in = {sh_q[6:0], si};
    assign wr_now  = (phase_q == P_DATA) && !rd_q;

    // ************************************************************
    // Read views
    // ************************************************************
    assign temp_view = pend_q ? `TSR_PENDING_WORD : temp_q;

    assign ctrl_word = {shdn_q, 9'h000, res_q, ready_q, alarm_q, 2'h0};

    // Register read mux, fed from the command byte still in the shift
    // register so the word is ready at the edge that takes the command;
    // unused bits or pointers read zero
    always @* begin
        rd_word = 16'h0000;
        case (sh_q[2:0])
            `TSR_PTR_CTRL: rd_word = ctrl_word;
            `TSR_PTR_HIGH: rd_word = high_q;
            `TSR_PTR_LOW:  rd_word = low_q;
            `TSR_PTR_ID:   rd_word = `TSR_ID_WORD;
            default:       rd_word = 16'h0000;
        endcase
        if (|sh_q[6:3]) begin
            rd_word = 16'h0000;
        end
    end

    // Mask low bits so the result sits left aligned
    always @* begin
        temp_fmt = conv_data;
        case (res_q)
            2'h0:    temp_fmt = {conv_data[15:3], 3'h0};
            2'h1:    temp_fmt = {conv_data[15:2], 2'h0};
            2'h2:    temp_fmt = {conv_data[15:1], 1'b0};
            default: temp_fmt = conv_data;
        endcase
    end

    // ************************************************************
    // Serial link and writable registers
    // ************************************************************
    // Device changes data on serial clock fall, samples on rise
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_q   <= P_IDLE;
            cnt_q     <= 5'd0;
            sh_q      <= 16'h0000;
            rd_q      <= 1'b0;
            ptr_q     <= 3'h0;
            sio_out_q <= 1'b0;
            sio_oe_q  <= 1'b0;
            shdn_q    <= 1'b0;
            res_q     <= `TSR_RST_RES;
            high_q    <= `TSR_RST_HIGH;
            low_q     <= `TSR_RST_LOW;
            os_go_q   <= 1'b0;
            aclr_q    <= 1'b0;
        end else begin
            os_go_q <= 1'b0;
            aclr_q  <= 1'b0;
            if (cs_hi) begin
                // Select high ends any field; partial bytes are lost
                phase_q  <= P_IDLE;
                sio_oe_q <= 1'b0;
            end else if (cs_fall) begin
                // Load the last completed result, or the pending word during a one-shot, first bit out at once
                phase_q   <= P_TEMP;
                cnt_q     <= 5'd0;
                sh_q      <= temp_view;
                sio_out_q <= temp_view[15];
                sio_oe_q  <= 1'b1;
            end else if (sc_rise && phase_q != P_IDLE) begin
                cnt_q <= cnt_n;
                if (phase_q == P_CMD || wr_now) begin
                    sh_q <= {sh_q[14:0], si};
                end
                // Upper byte latched after its eighth bit
                if (wr_now && cnt_n == `TSR_BYTE_BITS) begin
                    case (ptr_q)
                        `TSR_PTR_CTRL: begin
                            shdn_q  <= byte_in[`TSR_CTL_SHDN - 8];
                            os_go_q <= byte_in[`TSR_CTL_ONESHOT - 8];
                            aclr_q  <= byte_in[`TSR_CTL_ACLR - 8];
                        end
                        `TSR_PTR_HIGH: high_q[15:8] <= byte_in;
                        `TSR_PTR_LOW:  low_q[15:8]  <= byte_in;
                        default:       ;
                    endcase
                end
                // Lower byte completes the word; next command may follow
                if (wr_now && cnt_n == `TSR_WORD_BITS) begin
                    case (ptr_q)
                        `TSR_PTR_CTRL: res_q       <= byte_in[`TSR_CTL_RES_HI:`TSR_CTL_RES_LO];
                        `TSR_PTR_HIGH: high_q[7:0] <= byte_in;
                        `TSR_PTR_LOW:  low_q[7:0]  <= byte_in;
                        default:       ;
                    endcase
                    phase_q <= P_CMD;
                    cnt_q   <= 5'd0;
                end
            end else if (sc_fall) begin
                case (phase_q)
                    P_TEMP: begin
                        if (cnt_q == `TSR_WORD_BITS) begin
                            // Turn the data line around for the command
                            phase_q  <= P_CMD;
                            cnt_q    <= 5'd0;
                            sio_oe_q <= 1'b0;
                        end else begin
                            sh_q      <= {sh_q[14:0], 1'b0};
                            sio_out_q <= sh_q[14];
                        end
                    end
                    P_CMD: begin
                        if (cnt_q == `TSR_BYTE_BITS) begin
                            // Command taken on the eighth falling edge
                            rd_q    <= sh_q[`TSR_CMD_RD];
                            // Illegal command points nowhere, so writes drop
                            ptr_q   <= (|sh_q[6:3]) ? 3'h0 : sh_q[2:0];
                            phase_q <= P_DATA;
                            cnt_q   <= 5'd0;
                            if (sh_q[`TSR_CMD_RD]) begin
                                sh_q      <= rd_word;
                                sio_out_q <= rd_word[15];
                                sio_oe_q  <= 1'b1;
                            end
                        end
                    end
                    P_DATA: begin
                        if (rd_q && cnt_q == `TSR_WORD_BITS) begin
                            phase_q  <= P_CMD;
                            cnt_q    <= 5'd0;
                            sio_oe_q <= 1'b0;
                        end else if (rd_q) begin
                            sh_q      <= {sh_q[14:0], 1'b0};
                            sio_out_q <= sh_q[14];
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // ************************************************************
    // Conversion control, result and alarm comparator
    // ************************************************************
    // Continuous while out of shutdown, one conversion per one-shot
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cst_q     <= C_IDLE;
            start_q   <= 1'b0;
            pend_q    <= 1'b0;
            ready_q   <= 1'b0;
            temp_q    <= 16'h0000;
            alarm_q   <= 1'b0;
            alarm_n_q <= 1'b1;
        end else begin
            start_q <= 1'b0;
            case (cst_q)
                C_IDLE: begin
                    if (!shdn_q || os_go_q) begin
                        // Only temperature and flag change when pending
                        start_q <= 1'b1;
                        cst_q   <= C_BUSY;
                        if (shdn_q) begin
                            pend_q  <= 1'b1;
                            ready_q <= 1'b0;
                        end
                    end
                end
                C_BUSY: begin
                    if (conv_done) begin
                        temp_q  <= temp_fmt;
                        ready_q <= 1'b1;
                        pend_q  <= 1'b0;
                        cst_q   <= C_IDLE;
                    end
                end
                default: cst_q <= C_IDLE;
            endcase
            // Comparator runs only on completion; set beats clear
            if (cst_q == C_BUSY && conv_done &&
                $signed(temp_fmt) > $signed(high_q)) begin
                alarm_q   <= 1'b1;
                alarm_n_q <= 1'b0;
            end else if (aclr_q) begin
                alarm_q   <= 1'b0;
                alarm_n_q <= 1'b1;
            end else if (cst_q == C_BUSY && conv_done &&
                         $signed(temp_fmt) < $signed(low_q)) begin
                alarm_q   <= 1'b0;
                alarm_n_q <= 1'b1;
            end
            // Shutdown and one-shot leave the alarm alone
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign sio_out            = sio_out_q;
    assign sio_oe             = sio_oe_q;
    assign over_limit_alarm_n = alarm_n_q;
    assign conv_start         = start_q;
    assign conv_res           = res_q;

endmodule

`default_nettype wire

// >>> common/tsr_defs.vh
// Purpose : Constants of the temperature sensor serial readout block
// Assumes : Included by the design files by bare name
// Notes   : Definitions only
`ifndef TSR_DEFS_VH
`define TSR_DEFS_VH

// ************************************************************
// Register pointers carried in the command byte
// ************************************************************
`define TSR_PTR_CTRL      3'h1        // Control and status
`define TSR_PTR_HIGH      3'h2        // High limit
`define TSR_PTR_LOW       3'h3        // Low (hysteresis) limit
`define TSR_PTR_ID        3'h7        // Identification

// ************************************************************
// Command byte and control word field positions
// ************************************************************
`define TSR_CMD_RD        7           // Read (1) or write (0)
`define TSR_CTL_SHDN      15          // Shutdown
`define TSR_CTL_ONESHOT   14          // One-shot trigger, self clearing
`define TSR_CTL_ACLR      13          // Alarm clear, self clearing
`define TSR_CTL_RES_HI    5           // Resolution field, upper bit
`define TSR_CTL_RES_LO    4           // Resolution field, lower bit
`define TSR_CTL_READY     3           // Result ready flag, read only
`define TSR_CTL_ALARM     2           // Alarm state, read only

// ************************************************************
// Reset values and fixed words
// ************************************************************
`define TSR_RST_HIGH      16'h5000    // High limit after reset
`define TSR_RST_LOW       16'h4b00    // Low limit after reset
`define TSR_RST_RES       2'h0        // 13-bit resolution after reset
`define TSR_PENDING_WORD  16'h8000    // Temperature while one-shot pending
`define TSR_ID_WORD       16'h0a5a    // Identification, arbitrary value

// ************************************************************
// Link bit counts
// ************************************************************
`define TSR_WORD_BITS     5'd16       // Temperature and data word length
`define TSR_BYTE_BITS     5'd8        // Command byte and half word length

`endif

// >>> sim/tsr_sva.sv
// Purpose : Port-level checks of the temperature sensor readout
// Assumes : Sees only the ports of tsr_top; link pins sampled raw on clk
// Notes   : Bound into every tsr_top instance
`timescale 1ns/100ps
`default_nettype none
module tsr_sva (
    input wire logic       clk,                // System clock
    input wire logic       rst_n,              // Reset, active low
    input wire logic       cs_n,               // Chip select
    input wire logic       serial_clk,         // Serial clock
    input wire logic       sio_out,            // Data out
    input wire logic       sio_oe,             // Data drive enable
    input wire logic       over_limit_alarm_n, // Alarm, active low
    input wire logic       conv_start,         // Conversion start
    input wire logic [1:0] conv_res,           // Resolution
    input wire logic       conv_done           // Conversion done
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // A released select stops the drive within the synchroniser delay
    property p_oe_idle;
        cs_n [*6] |-> !sio_oe;
    endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("data line driven without select");
    // A falling select puts the first word bit on the line
    property p_cs_drive;
        $fell(cs_n) |-> ##[2:6] sio_oe;
    endproperty
    a_cs_drive: assert property (p_cs_drive) else $error("no drive after select");
    // Drive only starts inside a frame
    property p_oe_cs;
        $rose(sio_oe) |-> !cs_n;
    endproperty
    a_oe_cs: assert property (p_oe_cs) else $error("drive started outside a frame");
    // Bits hold while the host samples them
    property p_out_hold;
        $rose(serial_clk) && !cs_n && sio_oe |=> $stable(sio_out) [*3];
    endproperty
    a_out_hold: assert property (p_out_hold) else $error("data changed in high phase");
    // The alarm sets only from a finished conversion
    property p_alarm_fall;
        $fell(over_limit_alarm_n) |-> $past(conv_done) || $past(conv_done, 2);
    endproperty
    a_alarm_fall: assert property (p_alarm_fall) else $error("alarm set without result");
    // The alarm clears from a result or from a host write
    property p_alarm_rise;
        $rose(over_limit_alarm_n) |-> $past(conv_done) || $past(conv_done, 2) || !cs_n;
    endproperty
    a_alarm_rise: assert property (p_alarm_rise) else $error("alarm released without cause");
    // A start is a single pulse
    property p_start_once;
        conv_start |=> !conv_start;
    endproperty
    a_start_once: assert property (p_start_once) else $error("start pulse too long");
    // Resolution changes only by a host write
    property p_res_cs;
        $changed(conv_res) |-> !cs_n;
    endproperty
    a_res_cs: assert property (p_res_cs) else $error("resolution changed without write");
endmodule
bind tsr_top tsr_sva u_tsr_sva (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .serial_clk(serial_clk),
    .sio_out(sio_out), .sio_oe(sio_oe), .over_limit_alarm_n(over_limit_alarm_n),
    .conv_start(conv_start), .conv_res(conv_res), .conv_done(conv_done));
`default_nettype wire

// >>> sim/tsr_host.sv
// Purpose : Host model driving the three-wire link
// Assumes : Tasks are entered just after a clk rise; all delays keep that phase
// Notes   : Clock idles low; a line nobody drives shows a toggling pattern
`timescale 1ns/100ps
`default_nettype none
module tsr_host (
    output var logic cs_n,       // Chip select, active low
    output var logic serial_clk, // Serial clock, 320 ns period
    output wire logic sio_in,    // Resolved data line level
    input  wire logic sio_out,   // Device data value
    input  wire logic sio_oe     // Device drive enable
);
    logic        drv     = 1'b0;     // Host drives the line
    logic        d       = 1'b0;     // Host data bit
    logic        flt     = 1'b0;     // Pattern of the released line
    logic [15:0] rx_word = 16'h0000; // Last whole word read
    logic        rx_tick = 1'b0;     // Toggles per word read
    assign sio_in = sio_oe ? sio_out : (drv ? d : flt);
    initial cs_n = 1'b1;
    initial serial_clk = 1'b0;
    // Open a frame; clock stays still until the first bit
    task sel();
        cs_n = 1'b0;
        #320;
    endtask
    // Close a frame after the clock hold, then keep the bus free
    task desel();
        #80 cs_n = 1'b1;
        drv = 1'b0;
        #5000;
    endtask
    // Shift n bits MSB first; sample late in the high phase
    task bits(input int n, input logic [15:0] dout, input logic drive);
        logic [15:0] w;
        w = 16'h0000;
        drv = drive;
        for (int i = 0; i < n; i++) begin
            d = dout[15 - i];
            flt = ~flt;
            #160 serial_clk = 1'b1;
            #150 w = {w[14:0], sio_in};
            #10 serial_clk = 1'b0;
        end
        if (!drive && n == 16) begin
            rx_word = w;
            rx_tick = ~rx_tick;
        end
    endtask
endmodule
`default_nettype wire

// >>> sim/testbench.sv
// Purpose : Self-checking bench for the temperature sensor readout
// Assumes : Host model drives the link; the converter is modelled here
// Notes   : Words read are noted in a queue and compared on arrival
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic        clk       = 1'b0;     // 25 MHz clock
    logic        rst_n     = 1'b0;     // Reset, active low
    logic        conv_done = 1'b0;     // Converter finished
    logic [15:0] conv_data = 16'h0000; // Converter result
    logic [15:0] tin       = 16'h0000; // Die temperature
    logic [15:0] hi;                   // High limit written
    logic [15:0] lo;                   // Low limit written
    logic [15:0] exp_q[$];             // Expected words, oldest first
    int          lat       = 40;       // Conversion time in clk
    int          cnt       = 0;        // Conversion countdown
    int          n_starts  = 0;        // Conversions started
    int          n0        = 0;        // Start count mark
    int          n_errors  = 0;        // Mismatches
    int          n_checks  = 0;        // Comparisons
    wire         cs_n, serial_clk, sio_in, sio_out, sio_oe, over_limit_alarm_n, conv_start;
    wire [1:0]   conv_res;             // Resolution to converter
    logic [7:0]  rcmd[6] = '{8'h82, 8'h83, 8'h87, 8'h80, 8'h85, 8'h8a}; // Reads after reset
    logic [15:0] rval[6] = '{16'h5000, 16'h4b00, 16'h0a5a, 16'h0000, 16'h0000, 16'h0000};
    initial forever #20 clk = ~clk;
    tsr_top u_tsr_top (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .serial_clk(serial_clk), .sio_in(sio_in),
        .sio_out(sio_out), .sio_oe(sio_oe), .over_limit_alarm_n(over_limit_alarm_n),
        .conv_start(conv_start), .conv_res(conv_res), .conv_done(conv_done), .conv_data(conv_data));
    tsr_host u_tsr_host (.cs_n(cs_n), .serial_clk(serial_clk), .sio_in(sio_in), .sio_out(sio_out),
        .sio_oe(sio_oe));
    // Converter: hands over tin lat clk after each start
    always @(posedge clk) begin
        conv_done <= #1 (cnt == 1 && !conv_start);
        if (cnt == 1)
            conv_data <= #1 tin;
        if (conv_start) begin
            cnt      <= lat;
            n_starts <= n_starts + 1;
        end else if (cnt != 0)
            cnt <= cnt - 1;
    end
    // Each word the host reads meets its oldest note
    always @(u_tsr_host.rx_tick) check(u_tsr_host.rx_word, exp_q.pop_front());
    task check(input logic [15:0] seen, input logic [15:0] want);
        n_checks++;
        if (seen !== want) begin
            n_errors++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, want);
        end
    endtask
    task chk_al(input logic want);
        check({15'h0000, over_limit_alarm_n}, {15'h0000, want});
    endtask
    task wait_conv();
        repeat (lat + 60) @(posedge clk);
        #1;
    endtask
    task frame(input logic [15:0] want);
        u_tsr_host.sel();
        exp_q.push_back(want);
        u_tsr_host.bits(16, 16'h0000, 1'b0);
    endtask
    task rd(input logic [7:0] cmd, input logic [15:0] want);
        exp_q.push_back(want);
        u_tsr_host.bits(8, {cmd, 8'h00}, 1'b1);
        u_tsr_host.bits(16, 16'h0000, 1'b0);
    endtask
    task wr(input logic [7:0] cmd, input logic [15:0] v, input int n);
        u_tsr_host.bits(8, {cmd, 8'h00}, 1'b1);
        u_tsr_host.bits(n, v, 1'b1);
    endtask
    task done(input string s);
        u_tsr_host.desel();
        $display("test %s finished", s);
    endtask
    task stop_test();
        $display("checks %0d, mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Watchdog well beyond the expected half millisecond
    initial begin
        #2000000;
        n_errors++;
        stop_test();
    end
    initial begin
        tin = 16'($urandom(80723));
        repeat (10) @(posedge clk);
        #1 rst_n = 1'b1;
        wait_conv();
        frame(tin & 16'hfff8);
        foreach (rcmd[i]) rd(rcmd[i], rval[i]);
        done("reset values");
        hi = {4'h1, 9'($urandom), 3'h0};
        lo = hi - 16'h0400;
        frame(tin & 16'hfff8);
        wr(8'h02, hi, 16);
        wr(8'h03, lo, 16);
        rd(8'h82, hi);
        rd(8'h83, lo);
        done("limits");
        lo[15:8] = hi[15:8] - 8'h01;
        frame(tin & 16'hfff8);
        wr(8'h03, {lo[15:8], 8'hff}, 12);
        done("partial write");
        tin = hi + 16'h0008;
        wait_conv();
        chk_al(1'b0);
        frame(tin);
        rd(8'h83, lo);
        wr(8'h01, 16'h8000, 16);
        done("shutdown");
        wait_conv();
        n0 = n_starts;
        chk_al(1'b0);
        frame(tin);
        wr(8'h01, 16'ha000, 16);
        done("alarm clear");
        chk_al(1'b1);
        check(16'(n_starts - n0), 16'h0000);
        lat = 3000;
        tin = hi + 16'h0010;
        frame(hi + 16'h0008);
        wr(8'h01, 16'hc000, 16);
        rd(8'h82, hi);
        done("one-shot start");
        frame(16'h8000);
        rd(8'h81, 16'h8000);
        done("one-shot pending");
        wait_conv();
        check(16'(n_starts - n0), 16'h0001);
        chk_al(1'b0);
        lat = 40;
        frame(tin);
        rd(8'h81, 16'h800c);
        wr(8'h01, 16'h0000, 16);
        done("one-shot result");
        tin = lo + 16'h0008;
        wait_conv();
        chk_al(1'b0);
        tin = lo - 16'h0008;
        wait_conv();
        chk_al(1'b1);
        frame(tin);
        wr(8'h01, 16'h0030, 16);
        done("hysteresis");
        check({14'h0000, conv_res}, 16'h0003);
        tin = 16'($urandom);
        wait_conv();
        frame(tin);
        done("full resolution");
        u_tsr_host.sel();
        u_tsr_host.bits(5, 16'h0000, 1'b0);
        done("aborted read");
        frame(tin);
        done("after abort");
        stop_test();
    end
endmodule
`default_nettype wire
